/* File: src/mac_consts.vh */
/*
 * constants of the meter access and capture block: timing, service codes,
 * user input functions, access results and display states.
 * assumes it is included by bare name from the design files.
 */
`ifndef MAC_CONSTS_VH
`define MAC_CONSTS_VH

`define MAC_CLK_HZ        100000000
`define MAC_CAL_HOLD_S    2
`define MAC_CAL_BUSY_S    15
`define MAC_SCROLL_S      4
`define MAC_RESMSG_S      2
`define MAC_DELAY_MAX     14'h270f

`define MAC_SVC_RES       7'h55
`define MAC_SVC_FACTORY   7'h42
`define MAC_SVC_CAL       7'h30
`define MAC_CODE_MASTER   10'h0de
`define MAC_CODE_QUICK_HI 10'h063
`define MAC_CODE_MAX      10'h3e7

`define MAC_UFN_NONE      4'h0
`define MAC_UFN_PLOC      4'h1
`define MAC_UFN_RESET     4'h2
`define MAC_UFN_HOLD      4'h3
`define MAC_UFN_PRST      4'h7

`define MAC_ASN_PEAK      2'h1
`define MAC_ASN_VALLEY    2'h2
`define MAC_ASN_BOTH      2'h3

`define MAC_PROG_NONE     2'h0
`define MAC_PROG_QUICK    2'h1
`define MAC_PROG_ACCESS   2'h2
`define MAC_PROG_FULL     2'h3

`define MAC_SV_IDLE       3'h0
`define MAC_SV_RESMSG     3'h1
`define MAC_SV_PROMPT     3'h2
`define MAC_SV_CALPROMPT  3'h3
`define MAC_SV_CALBUSY    3'h4

`define MAC_SP_IDLE       2'h0
`define MAC_SP_CHOICE     2'h1
`define MAC_SP_EDIT       2'h2

`define MAC_INT_MIN       3'h1
`define MAC_INT_MAX       3'h5
`define MAC_INT_RESET     3'h3

`endif

/* File: src/mac_xcap.v */
/*
 * one extreme-value capture channel: holds the stored peak or valley and
 * replaces it once the display has stayed beyond it for the delay.
 * assumes tick is a one-cycle pulse once per second on mclk.
 */
`timescale 1ns/100ps
`include "mac_consts.vh"
module mac_xcap #(
  parameter DW   = 17,
  parameter HIGH = 1
) (
  input  wire                 mclk,
  input  wire                 rstn,
  input  wire                 tick,
  input  wire                 enable,
  input  wire signed [DW-1:0] disp,
  input  wire        [13:0]   delay,
  input  wire                 reset_now,
  output reg  signed [DW-1:0] stored
);
  localparam signed [DW-1:0] START = HIGH ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
  reg  [13:0] secs;
  wire        beyond = HIGH ? (disp > stored) : (disp < stored);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stored <= START;
      secs   <= 14'h0000;
    end else if (reset_now) begin
      stored <= disp;
      secs   <= 14'h0000;
    end else if (!enable || !beyond) begin
      secs <= 14'h0000;                            // see R3
    end else if (secs >= delay) begin
      stored <= disp;                              // see R1 see R2
      secs   <= 14'h0000;
    end else if (tick) begin
      secs <= secs + 14'h0001;
    end
  end
endmodule

/* File: src/mac_top.v */
/*
 * control logic of a panel temperature meter: peak/valley capture, service
 * codes, calibration timing, display stepping and scrolling, intensity,
 * programming access and the setpoint menu.
 * assumes keys and the user input are raw pins (active high when pressed or
 * active); all other inputs come from logic on mclk, strobes last one cycle.
 */
//
// Summary of operation
// R1: peak replaced only after display stays above it for the capture delay.
// R2: valley replaced only after display stays below it for the delay.
// R3: capture delay restarts whenever display stops exceeding the stored extreme.
// R4: service code 85 toggles resistance display mode.
// R5: power-up always starts in temperature display mode.
// R6: service code 66 loads defaults, shows reset message, then prompt 00.
// R7: both keys held at power-up load defaults and show reset message.
// R8: at service prompt 48, advance key held 2 s enters calibration.
// R9: each calibration acquisition shows busy for 15 s before next prompt.
// R10: scrolling advances to next enabled display every 4 s.
// R11: with display select enabled, each advance press steps the display; the code steps only outside programming (prog_mode MAC_PROG_NONE).
// R12: intensity accepted from 1 to 5 and applied at once.
// R13: nonzero code needs matching entry; zero without lock-out grants full access.
// R14: codes 1-99 open quick programming before the access prompt.
// R15: codes 100-999 go straight to the access prompt.
// R16: active lock-out: code 0 blocks, 1-99 quick only; inactive grants full.
// R17: code 222 at the access prompt always grants full programming.
// R18: user input assignment acts only for reset, hold, print-and-reset.
// R19: finishing a setpoint returns to choice prompt; no exits the menu.
// R20: second setpoint disabled returns to choice prompt without parameters.
// R21: four setpoint actions: high or low acting, balanced or unbalanced.
`timescale 1ns/100ps
`include "mac_consts.vh"
module mac_top #(
  parameter DW          = 17,
  parameter TICK_CYCLES = `MAC_CLK_HZ
) (
  input  wire                 mclk,
  input  wire                 rstn,
  input  wire                 key_adv,
  input  wire                 key_rst,
  input  wire                 key_prog,
  input  wire                 user_in,
  input  wire signed [DW-1:0] disp_value,
  input  wire                 peak_en,
  input  wire                 valley_en,
  input  wire        [13:0]   peak_delay,
  input  wire        [13:0]   valley_delay,
  input  wire        [3:0]    user_fn,
  input  wire        [1:0]    user_assign,
  input  wire                 svc_active,
  input  wire        [6:0]    svc_code,
  input  wire                 svc_enter,
  input  wire                 cal_acquire,
  input  wire                 cal_exit,
  input  wire        [2:0]    disp_mask,
  input  wire                 scroll_en,
  input  wire                 sel_en,
  input  wire        [2:0]    intensity_in,
  input  wire        [9:0]    security_code,
  input  wire        [9:0]    access_code,
  input  wire                 access_enter,
  input  wire                 quick_done,
  input  wire                 prog_exit,
  input  wire                 sp_menu,
  input  wire        [1:0]    sp_pick,
  input  wire                 sp_pick_go,
  input  wire                 sp_done,
  input  wire                 sp2_enable,
  input  wire        [1:0]    sp_action_in,
  output reg  signed [DW-1:0] peak_value_target,
  output reg  signed [DW-1:0] valley_value_target,
  output reg                  disp_hold,
  output reg                  res_mode,
  output reg                  factory_load,
  output reg         [2:0]    svc_state,
  output reg                  cal_next,
  output reg         [1:0]    disp_sel,
  output reg         [2:0]    intensity,
  output reg         [1:0]    prog_mode,
  output reg         [1:0]    sp_state,
  output reg         [1:0]    sp_current,
  output reg                  sp2_active,
  output reg         [1:0]    sp1_action,
  output reg         [1:0]    sp2_action
);
  localparam [1:0] high_act_balanced   = 2'h0;     // see R21
  localparam [1:0] low_act_balanced    = 2'h1;
  localparam [1:0] high_act_unbalanced = 2'h2;
  localparam [1:0] low_act_unbalanced  = 2'h3;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // two-stage synchronisers, then one more stage for edge detection
  reg  [3:0] pin_s1;
  reg  [3:0] pin_s2;
  reg  [3:0] pin_d;
  wire adv   = pin_s2[0];
  wire rst_k = pin_s2[1];
  wire uin   = pin_s2[3];
  wire adv_p  = pin_s2[0] & ~pin_d[0];
  wire prog_p = pin_s2[2] & ~pin_d[2];
  wire uin_p  = pin_s2[3] & ~pin_d[3];

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_d  <= 4'h0;
    end else begin
      pin_s1 <= {user_in, key_prog, key_rst, key_adv};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  // free-running one-second tick
  reg  [31:0] pre;
  reg         tick;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre  <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= (pre == TICK_LAST);
      pre  <= (pre == TICK_LAST) ? 32'h0000_0000 : pre + 32'h0000_0001;
    end
  end

  // user input assignment is honoured only for reset-type and hold functions
  wire asn_live  = (user_fn == `MAC_UFN_RESET) | (user_fn == `MAC_UFN_HOLD) |
                   (user_fn == `MAC_UFN_PRST);                     // see R18
  wire ureset    = uin_p & ((user_fn == `MAC_UFN_RESET) | (user_fn == `MAC_UFN_PRST));
  wire rst_peak  = ureset & asn_live & user_assign[0];
  wire rst_vall  = ureset & asn_live & user_assign[1];
  wire lock_on   = (user_fn == `MAC_UFN_PLOC) & uin;
  wire lock_off  = (user_fn == `MAC_UFN_PLOC) & ~uin;

  wire signed [DW-1:0] peak_s;
  wire signed [DW-1:0] vall_s;

  mac_xcap #(.DW(DW), .HIGH(1)) u_peak (
    .mclk      (mclk),
    .rstn      (rstn),
    .tick      (tick),
    .enable    (peak_en),
    .disp      (disp_value),
    .delay     (peak_delay),
    .reset_now (rst_peak),
    .stored    (peak_s)
  );

  mac_xcap #(.DW(DW), .HIGH(0)) u_valley (
    .mclk      (mclk),
    .rstn      (rstn),
    .tick      (tick),
    .enable    (valley_en),
    .disp      (disp_value),
    .delay     (valley_delay),
    .reset_now (rst_vall),
    .stored    (vall_s)
  );

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      peak_value_target   <= {DW{1'b0}};
      valley_value_target <= {DW{1'b0}};
      disp_hold           <= 1'b0;
    end else begin
      peak_value_target   <= peak_s;
      valley_value_target <= vall_s;
      disp_hold           <= (user_fn == `MAC_UFN_HOLD) & uin & (user_assign != 2'h0);
    end
  end

  // service code machine with its own second counter, restarted per state
  reg  [1:0]  boot;
  reg  [31:0] sv_cyc;
  reg  [4:0]  sv_sec;
  wire        sv_tick = (sv_cyc == TICK_LAST);
  reg         sv_new;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      boot         <= 2'h0;
      res_mode     <= 1'b0;                        // see R5
      factory_load <= 1'b0;
      svc_state    <= `MAC_SV_IDLE;
      cal_next     <= 1'b0;
      sv_cyc       <= 32'h0000_0000;
      sv_sec       <= 5'h00;
      sv_new       <= 1'b0;
    end else begin
      factory_load <= 1'b0;
      cal_next     <= 1'b0;
      sv_new       <= 1'b0;
      if (sv_new) begin
        sv_cyc <= 32'h0000_0000;
        sv_sec <= 5'h00;
      end else if (sv_tick) begin
        sv_cyc <= 32'h0000_0000;
        sv_sec <= sv_sec + 5'h01;
      end else begin
        sv_cyc <= sv_cyc + 32'h0000_0001;
      end
      if (boot != 2'h3)
        boot <= boot + 2'h1;
      if (boot == 2'h2 && adv && rst_k) begin
        factory_load <= 1'b1;                      // see R7
        svc_state    <= `MAC_SV_RESMSG;
        sv_new       <= 1'b1;
      end else begin
        case (svc_state)
          `MAC_SV_IDLE: begin
            if (svc_active) begin
              svc_state <= `MAC_SV_PROMPT;
              sv_new    <= 1'b1;
            end
          end
          `MAC_SV_RESMSG: begin
            if (sv_sec == `MAC_RESMSG_S)
              svc_state <= svc_active ? `MAC_SV_PROMPT : `MAC_SV_IDLE;  // see R6
          end
          `MAC_SV_PROMPT: begin
            if (!svc_active) begin
              svc_state <= `MAC_SV_IDLE;
            end else if (svc_enter && svc_code == `MAC_SVC_RES) begin
              res_mode <= ~res_mode;               // see R4
            end else if (svc_enter && svc_code == `MAC_SVC_FACTORY) begin
              factory_load <= 1'b1;                // see R6
              svc_state    <= `MAC_SV_RESMSG;
              sv_new       <= 1'b1;
            end else if (svc_code != `MAC_SVC_CAL || !adv) begin
              sv_new <= 1'b1;
            end else if (sv_sec == `MAC_CAL_HOLD_S) begin
              svc_state <= `MAC_SV_CALPROMPT;      // see R8
            end
          end
          `MAC_SV_CALPROMPT: begin
            if (cal_exit) begin
              svc_state <= `MAC_SV_PROMPT;
              sv_new    <= 1'b1;
            end else if (cal_acquire) begin
              svc_state <= `MAC_SV_CALBUSY;
              sv_new    <= 1'b1;
            end
          end
          `MAC_SV_CALBUSY: begin
            if (sv_sec == `MAC_CAL_BUSY_S) begin
              svc_state <= `MAC_SV_CALPROMPT;      // see R9
              cal_next  <= 1'b1;
            end
          end
          default: svc_state <= `MAC_SV_IDLE;
        endcase
      end
    end
  end

  // display stepping: next enabled display after the current one
  reg  [2:0] sc_sec;
  reg  [1:0] nxt;
  always @* begin
    nxt = disp_sel;
    if (disp_mask[(disp_sel + 2'h1) % 3])
      nxt = (disp_sel == 2'h2) ? 2'h0 : disp_sel + 2'h1;
    else if (disp_mask[(disp_sel + 2'h2) % 3])
      nxt = (disp_sel == 2'h0) ? 2'h2 : disp_sel - 2'h1;
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      disp_sel  <= 2'h0;
      sc_sec    <= 3'h0;
      intensity <= `MAC_INT_RESET;
    end else begin
      if (!scroll_en) begin
        sc_sec <= 3'h0;
      end else if (tick) begin
        sc_sec <= (sc_sec == `MAC_SCROLL_S - 1) ? 3'h0 : sc_sec + 3'h1;
      end
      if (sel_en && adv_p && prog_mode == `MAC_PROG_NONE)
        disp_sel <= nxt;                           // see R11
      else if (scroll_en && tick && sc_sec == `MAC_SCROLL_S - 1)
        disp_sel <= nxt;                           // see R10
      if (intensity_in >= `MAC_INT_MIN && intensity_in <= `MAC_INT_MAX)
        intensity <= intensity_in;                 // see R12
    end
  end

  // programming access
  wire code_zero  = (security_code == 10'h000);
  wire code_quick = ~code_zero & (security_code <= `MAC_CODE_QUICK_HI);
  wire code_ok    = (access_code == `MAC_CODE_MASTER) |                   // see R17
                    (~code_zero & access_code == security_code);         // see R13

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prog_mode <= `MAC_PROG_NONE;
    end else begin
      case (prog_mode)
        `MAC_PROG_NONE: begin
          if (prog_p) begin
            if (lock_off)
              prog_mode <= `MAC_PROG_FULL;                         // see R16
            else if (!lock_on)
              prog_mode <= code_zero ? `MAC_PROG_FULL :           // see R13
                           code_quick ? `MAC_PROG_QUICK :          // see R14
                           `MAC_PROG_ACCESS;                       // see R15
            else if (code_quick)
              prog_mode <= `MAC_PROG_QUICK;                        // see R16
            else if (!code_zero)
              prog_mode <= `MAC_PROG_ACCESS;
          end
        end
        `MAC_PROG_QUICK: begin
          if (prog_exit)
            prog_mode <= `MAC_PROG_NONE;
          else if (quick_done)
            prog_mode <= lock_on ? `MAC_PROG_NONE : `MAC_PROG_ACCESS;  // see R16
        end
        `MAC_PROG_ACCESS: begin
          if (prog_exit)
            prog_mode <= `MAC_PROG_NONE;
          else if (access_enter)
            prog_mode <= code_ok ? `MAC_PROG_FULL : `MAC_PROG_NONE;    // see R13 see R17
        end
        `MAC_PROG_FULL: begin
          if (prog_exit)
            prog_mode <= `MAC_PROG_NONE;
        end
        default: prog_mode <= `MAC_PROG_NONE;
      endcase
    end
  end

  // setpoint menu
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sp_state   <= `MAC_SP_IDLE;
      sp_current <= 2'h0;
      sp2_active <= 1'b0;
      sp1_action <= high_act_balanced;
      sp2_action <= high_act_balanced;
    end else begin
      case (sp_state)
        `MAC_SP_IDLE: begin
          if (sp_menu && prog_mode == `MAC_PROG_FULL)
            sp_state <= `MAC_SP_CHOICE;
        end
        `MAC_SP_CHOICE: begin
          if (sp_pick_go) begin
            sp_current <= sp_pick;
            if (sp_pick == 2'h0) begin
              sp_state <= `MAC_SP_IDLE;            // see R19
            end else if (sp_pick == 2'h2 && !sp2_enable) begin
              sp2_active <= 1'b0;                  // see R20
            end else begin
              sp2_active <= (sp_pick == 2'h2) | sp2_active;
              sp_state   <= `MAC_SP_EDIT;
            end
          end
        end
        `MAC_SP_EDIT: begin
          if (sp_done) begin
            if (sp_current == 2'h1)
              sp1_action <= sp_action_in;          // see R21
            else
              sp2_action <= sp_action_in;
            sp_state <= `MAC_SP_CHOICE;            // see R19
          end
        end
        default: sp_state <= `MAC_SP_IDLE;
      endcase
    end
  end
endmodule

/* File: sim/mac_props.sv */
/* assertions on the ports of the meter access and capture block.
   assumes it is bound into mac_top and sees only that module's ports. */
`timescale 1ns/100ps
module mac_props #(
  parameter DW          = 17,
  parameter TICK_CYCLES = 100000000
) (
  input wire                 mclk,
  input wire                 rstn,
  input wire signed [DW-1:0] disp_value,
  input wire                 peak_en,
  input wire                 valley_en,
  input wire        [13:0]   peak_delay,
  input wire        [13:0]   valley_delay,
  input wire        [3:0]    user_fn,
  input wire        [6:0]    svc_code,
  input wire                 svc_enter,
  input wire                 cal_exit,
  input wire        [9:0]    security_code,
  input wire        [9:0]    access_code,
  input wire                 access_enter,
  input wire signed [DW-1:0] peak_value_target,
  input wire signed [DW-1:0] valley_value_target,
  input wire                 res_mode,
  input wire                 factory_load,
  input wire        [2:0]    svc_state,
  input wire        [2:0]    intensity,
  input wire        [1:0]    prog_mode,
  input wire        [2:0]    intensity_in,
  input wire                 cal_next
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  integer up_run;
  integer dn_run;
  integer busy_run;
  wire    no_ures;
  // a user reset may move the extremes at any time, so it is excluded
  assign no_ures = (user_fn != 4'h2) && (user_fn != 4'h7);
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      up_run   <= 0;
      dn_run   <= 0;
      busy_run <= 0;
    end else begin
      up_run   <= (peak_en && disp_value > peak_value_target) ? up_run + 1 : 0;
      dn_run   <= (valley_en && disp_value < valley_value_target) ? dn_run + 1 : 0;
      busy_run <= (svc_state == 3'h4) ? busy_run + 1 : 0;
    end
  end
  sequence s_svc(c);
    svc_enter && svc_state == 3'h2 && svc_code == c;
  endsequence
  sequence s_msg;
    factory_load && svc_state == 3'h1 ##1 !factory_load && svc_state == 3'h1;
  endsequence
  AST_RES_TOGGLE: assert property (s_svc(7'h55) |=> res_mode != $past(res_mode))
    else $error("resistance mode did not toggle");
  AST_FACTORY: assert property (s_svc(7'h42) |=> s_msg)
    else $error("defaults load or reset message missing");
  AST_PEAK_DELAY: assert property (no_ures && peak_value_target > $past(peak_value_target)
    |-> up_run + TICK_CYCLES >= peak_delay * TICK_CYCLES)
    else $error("peak captured before the delay");
  AST_VALLEY_DELAY: assert property (no_ures && valley_value_target < $past(valley_value_target)
    |-> dn_run + TICK_CYCLES >= valley_delay * TICK_CYCLES)
    else $error("valley captured before the delay");
  AST_CAL_BUSY: assert property ($fell(svc_state == 3'h4) && !$past(cal_exit) |->
    svc_state == 3'h3 && cal_next && busy_run >= 14 * TICK_CYCLES && busy_run <= 16 * TICK_CYCLES)
    else $error("calibration busy time wrong");
  AST_INTENSITY: assert property (intensity >= 3'h1 && intensity <= 3'h5 &&
    (intensity == $past(intensity_in) || intensity == $past(intensity)))
    else $error("intensity out of range");
  AST_MASTER: assert property (access_enter && prog_mode == 2'h2 && access_code == 10'h0de
    |=> prog_mode == 2'h3)
    else $error("master code refused");
  AST_WRONG: assert property (access_enter && prog_mode == 2'h2 && access_code != 10'h0de
    && (access_code != security_code || security_code == 10'h000) |=> prog_mode == 2'h0)
    else $error("wrong code granted access");
endmodule
bind mac_top mac_props #(.DW(DW), .TICK_CYCLES(TICK_CYCLES)) mac_props_i (.mclk, .rstn,
  .disp_value, .peak_en, .valley_en, .peak_delay, .valley_delay, .user_fn, .svc_code,
  .svc_enter, .cal_exit, .security_code, .access_code, .access_enter, .peak_value_target,
  .valley_value_target, .res_mode, .factory_load, .svc_state, .intensity, .prog_mode,
  .intensity_in, .cal_next);

/* File: sim/mac_panel.sv */
/* operator side: front-panel keys and the user input line.
   assumes the bench calls its tasks; pins change at falling edges of mclk. */
`timescale 1ns/100ps
module mac_panel (
  input  wire mclk,
  output reg  key_adv,
  output reg  key_rst,
  output reg  key_prog,
  output reg  user_in
);
  initial begin
    {key_prog, key_rst, key_adv} = 3'h0;
    user_in = 1'b0;
  end
  // hold keys {prog, rst, adv} for c cycles, through power-up or for long holds
  task tap(input logic [2:0] m, input integer c);
    @(negedge mclk);
    {key_prog, key_rst, key_adv} = m;
    repeat (c) @(negedge mclk);
    {key_prog, key_rst, key_adv} = 3'h0;
  endtask
  task level(input logic v);
    @(negedge mclk);
    user_in = v;
  endtask
endmodule

/* File: sim/mac_top_tb_top.sv */
/* self-checking bench for the meter access and capture block.
   assumes mac_top, mac_panel and the bound checker are compiled with it. */
`timescale 1ns/100ps
module mac_top_tb_top;
  localparam TICK = 10;
  localparam logic [16:0] ACC [0:6] = '{{4'h0, 1'b0, 10'h000, 2'h3},
    {4'h0, 1'b0, 10'h032, 2'h1}, {4'h0, 1'b0, 10'h1f4, 2'h2}, {4'h1, 1'b1, 10'h000, 2'h0},
    {4'h1, 1'b1, 10'h032, 2'h1}, {4'h1, 1'b1, 10'h1f4, 2'h2}, {4'h1, 1'b0, 10'h032, 2'h3}};
  logic               mclk = 1'b0;
  logic               rstn = 1'b0;
  wire                key_adv, key_rst, key_prog, user_in;
  logic signed [16:0] disp_value = 17'h00000;
  logic        [13:0] peak_delay = 14'h0000, valley_delay = 14'h0000;
  logic        [3:0]  user_fn = 4'h0;
  logic        [6:0]  svc_code = 7'h00;
  logic        [2:0]  disp_mask = 3'h7, intensity_in = 3'h3;
  logic        [9:0]  security_code = 10'h000, access_code = 10'h000;
  logic        [1:0]  user_assign = 2'h0, sp_pick = 2'h0, sp_action_in = 2'h0, em, d;
  logic               peak_en = 1'b0, valley_en = 1'b0, svc_active = 1'b0, svc_enter = 1'b0;
  logic               cal_acquire = 1'b0, cal_exit = 1'b0, scroll_en = 1'b0, sel_en = 1'b0;
  logic               access_enter = 1'b0, quick_done = 1'b0, prog_exit = 1'b0, sp_menu = 1'b0;
  logic               sp_pick_go = 1'b0, sp_done = 1'b0, sp2_enable = 1'b1, lk;
  wire signed  [16:0] peak_value_target, valley_value_target;
  wire         [2:0]  svc_state, intensity;
  wire         [1:0]  disp_sel, prog_mode, sp_state, sp_current, sp1_action, sp2_action;
  wire                disp_hold, res_mode, factory_load, cal_next, sp2_active;
  integer             n_fail = 0, samples_checked = 0, i, n;
  mac_top #(.DW(17), .TICK_CYCLES(TICK)) mac_top_i (.mclk, .rstn, .key_adv, .key_rst,
    .key_prog, .user_in, .disp_value, .peak_en, .valley_en, .peak_delay, .valley_delay,
    .user_fn, .user_assign, .svc_active, .svc_code, .svc_enter, .cal_acquire, .cal_exit,
    .disp_mask, .scroll_en, .sel_en, .intensity_in, .security_code, .access_code,
    .access_enter, .quick_done, .prog_exit, .sp_menu, .sp_pick, .sp_pick_go, .sp_done,
    .sp2_enable, .sp_action_in, .peak_value_target, .valley_value_target, .disp_hold,
    .res_mode, .factory_load, .svc_state, .cal_next, .disp_sel, .intensity, .prog_mode,
    .sp_state, .sp_current, .sp2_active, .sp1_action, .sp2_action);
  mac_panel mac_panel_i (.mclk, .key_adv, .key_rst, .key_prog, .user_in);
  initial begin
    forever #5 mclk = ~mclk;
  end
  task cyc(input integer c);
    repeat (c) @(negedge mclk);
  endtask
  // one-cycle strobe, then room for the registered answer
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask
  task press(input logic [2:0] m, input integer c);
    mac_panel_i.tap(m, c);
    cyc(6);
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task t_capture;
    disp_value = 17'h0000a;
    peak_en = 1'b1;
    valley_en = 1'b1;
    cyc(6);
    check(valley_value_target, 32'h0000000a);
    peak_delay = 14'h0003;
    valley_delay = 14'h0002;
    disp_value = 17'h00064;
    cyc(15);
    disp_value = 17'h0000a;
    cyc(3);
    disp_value = 17'h00064;
    cyc(15);
    check(peak_value_target, 32'h0000000a);
    cyc(25);
    check(peak_value_target, 32'h00000064);
    disp_value = 17'h1ffec;
    cyc(8);
    check(valley_value_target, 32'h0000000a);
    cyc(20);
    check(valley_value_target, 32'hffffffec);
  endtask
  task t_service;
    svc_active = 1'b1;
    cyc(3);
    svc_code = 7'h55;
    pulse(svc_enter);
    check(res_mode, 1);
    pulse(svc_enter);
    check(res_mode, 0);
    svc_code = 7'h42;
    pulse(svc_enter);
    check(svc_state, 1);
    cyc(25);
    check(svc_state, 2);
    svc_code = 7'h30;
    press(3'b001, 12);
    check(svc_state, 2);
    press(3'b001, 30);
    check(svc_state, 3);
    pulse(cal_acquire);
    cyc(130);
    check(svc_state, 4);
    cyc(25);
    check(svc_state, 3);
    pulse(cal_exit);
    svc_active = 1'b0;
    cyc(3);
  endtask
  task t_display;
    sel_en = 1'b1;
    for (i = 1; i < 4; i++) begin
      press(3'b001, 3);
      check(disp_sel, i % 3);
    end
    disp_mask = 3'h5;
    press(3'b001, 3);
    check(disp_sel, 2);
    sel_en = 1'b0;
    disp_mask = 3'h7;
    scroll_en = 1'b1;
    for (i = 0; i < 2; i++) begin
      d = disp_sel;
      n = 0;
      while (disp_sel === d && n < 60) begin
        cyc(1);
        n++;
      end
    end
    check(n, 4 * TICK);
    scroll_en = 1'b0;
    for (i = 0; i < 4; i++) begin
      intensity_in = 16'h1605 >> (4 * i);
      cyc(3);
      check(intensity, (16'h1555 >> (4 * i)) & 16'h0007);
    end
    user_fn = 4'h3;
    user_assign = 2'h1;
    mac_panel_i.level(1'b1);
    cyc(6);
    check(disp_hold, 1);
    user_fn = 4'h4;
    cyc(4);
    check(disp_hold, 0);
    disp_value = 17'h00005;
    for (i = 0; i < 2; i++) begin
      user_fn = i ? 4'h4 : 4'h2;
      user_assign = i ? 2'h2 : 2'h1;
      mac_panel_i.level(1'b0);
      cyc(4);
      mac_panel_i.level(1'b1);
      cyc(6);
      check(peak_value_target, 32'h00000005);
      check(valley_value_target, 32'hffffffec);
    end
  endtask
  task t_access;
    for (i = 0; i < 7; i++) begin
      {user_fn, lk, security_code, em} = ACC[i];
      mac_panel_i.level(lk);
      cyc(6);
      press(3'b100, 3);
      check(prog_mode, em);
      pulse(prog_exit);
    end
    mac_panel_i.level(1'b0);
    user_fn = 4'h0;
    security_code = 10'h1f4;
    for (i = 0; i < 3; i++) begin
      press(3'b100, 3);
      access_code = 30'h0de7d1f3 >> (10 * i);
      pulse(access_enter);
      check(prog_mode, (i == 0) ? 0 : 3);
      pulse(prog_exit);
    end
    security_code = 10'h032;
    press(3'b100, 3);
    pulse(quick_done);
    check(prog_mode, 2);
    access_code = 10'h032;
    pulse(access_enter);
    check(prog_mode, 3);
  endtask
  task t_setpoint;
    pulse(sp_menu);
    for (i = 0; i < 4; i++) begin
      sp_pick = 2'h1;
      pulse(sp_pick_go);
      check(sp_state, 2);
      sp_action_in = i;
      pulse(sp_done);
      check(sp_state, 1);
      check(sp1_action, i);
    end
    sp_pick = 2'h2;
    pulse(sp_pick_go);
    check(sp_current, 2);
    check(sp2_active, 1);
    sp_action_in = 2'h3;
    pulse(sp_done);
    check(sp2_action, 3);
    sp2_enable = 1'b0;
    pulse(sp_pick_go);
    check(sp_state, 1);
    check(sp2_active, 0);
    sp_pick = 2'h0;
    pulse(sp_pick_go);
    check(sp_state, 0);
    pulse(prog_exit);
  endtask
  initial begin
    fork
      mac_panel_i.tap(3'b011, 18);
    join_none
    cyc(12);
    rstn = 1'b1;
    cyc(6);
    check(svc_state, 1);
    check(res_mode, 0);
    check(intensity, 3);
    cyc(30);
    t_capture;
    t_service;
    t_display;
    t_access;
    t_setpoint;
    conclude;
  end
  initial begin
    repeat (6000) @(posedge mclk);
    n_fail++;
    conclude;
  end
endmodule
